// [hw/power_manager_params.svh]
// Offsets-free timing and reset constants of the power manager pin control.
`ifndef POWER_MANAGER_PARAMS_SVH
`define POWER_MANAGER_PARAMS_SVH

`define CLK_PERIOD_NS   10
`define SEQ_STEP_NS     1000
`define SEQ_STEP_CYC    ((`SEQ_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REPROG_NS       2000
`define REPROG_CYC      ((`REPROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_BIT_NS     2000
`define SYNC_BIT_CYC    (`SYNC_BIT_NS / `CLK_PERIOD_NS)
`define SYNC_ONE_NS     500
`define SYNC_ONE_CYC    ((`SYNC_ONE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_ZERO_NS    1500
`define SYNC_ZERO_CYC   ((`SYNC_ZERO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_SAMPLE_NS  1000
`define SYNC_SAMPLE_CYC (`SYNC_SAMPLE_NS / `CLK_PERIOD_NS)
`define SEQ_LAST_STEP   3'd4
`define SYNC_VEC_W      21
`define SYNC_VEC_RST    21'h0f_ffff

`endif

// [hw/power_manager_pkg.sv]
// Types shared by the power manager pin control.
package power_manager_pkg;

  typedef enum logic [2:0] {
    ST_COLD,
    ST_REPROG,
    ST_RUN,
    ST_SEQ_OFF,
    ST_HELD,
    ST_SHUT
  } state_t;

endpackage : power_manager_pkg

// [hw/sync_line_tx.sv]
// Clock and message driver for the shared open-drain sync line.
`include "power_manager_params.svh"

module sync_line_tx #(
  parameter int BIT_CYC    = `SYNC_BIT_CYC,
  parameter int ONE_CYC    = `SYNC_ONE_CYC,
  parameter int ZERO_CYC   = `SYNC_ZERO_CYC,
  parameter int SAMPLE_CYC = `SYNC_SAMPLE_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  input  wire logic       line_sync,
  output logic            line_oe,
  output logic [7:0]      rx_data,
  output logic            rx_valid
);

  if (!(ONE_CYC > 0 && ONE_CYC < SAMPLE_CYC && SAMPLE_CYC < ZERO_CYC &&
        ZERO_CYC < BIT_CYC && BIT_CYC < 65536)) begin : g_bad_timing
    $error("sync line timing out of order");
  end

  logic [15:0] bit_cnt_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  rx_shift_reg;
  logic [3:0]  bits_left_reg;
  logic        cur_bit;
  logic        at_end;

  // Idle periods still carry the clock, coded as ones.
  assign cur_bit = (bits_left_reg != 4'h0) ? shift_reg[7] : 1'b1;
  assign at_end  = (bit_cnt_reg == 16'(BIT_CYC - 1));

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      bit_cnt_reg <= 16'h0000;
    end else if (at_end) begin
      bit_cnt_reg <= 16'h0000;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 16'h0001;
    end
  end

  // Every period starts with a falling edge; its low width codes the bit.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      line_oe <= 1'b0;
    end else if (bit_cnt_reg == 16'h0000) begin
      line_oe <= 1'b1;
    end else if (bit_cnt_reg == 16'(cur_bit ? ONE_CYC : ZERO_CYC)) begin
      line_oe <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      shift_reg     <= 8'h00;
      bits_left_reg <= 4'h0;
      tx_ready      <= 1'b0;
    end else if (at_end && bits_left_reg != 4'h0) begin
      shift_reg     <= {shift_reg[6:0], 1'b0};
      bits_left_reg <= bits_left_reg - 4'h1;
      tx_ready      <= (bits_left_reg == 4'h1);
    end else if (at_end && tx_valid && tx_ready) begin
      shift_reg     <= tx_data;
      bits_left_reg <= 4'h8;
      tx_ready      <= 1'b0;
    end else begin
      tx_ready      <= (bits_left_reg == 4'h0);
    end
  end

  // A converter answering holds the line low past the sample point.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      rx_shift_reg <= 8'h00;
      rx_data      <= 8'h00;
      rx_valid     <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (bit_cnt_reg == 16'(SAMPLE_CYC)) begin
        rx_shift_reg <= {rx_shift_reg[6:0], line_sync};
        if (bits_left_reg == 4'h1) begin
          rx_data  <= {rx_shift_reg[6:0], line_sync};
          rx_valid <= 1'b1;
        end
      end
    end
  end

  AST_SYNC_CLOCK: assert property (@(posedge core_clk) disable iff (!nrst)
    (bit_cnt_reg == 16'h0000) |=> line_oe [*8])
    else $error("sync line clock edge missing");

  AST_SYNC_ONE_RELEASE: assert property (@(posedge core_clk)
    disable iff (!nrst)
    (bits_left_reg == 4'h0 && bit_cnt_reg == 16'(ONE_CYC)) |=> !line_oe)
    else $error("idle one bit not released on time");

endmodule : sync_line_tx

// [hw/power_manager_pin_control.sv]
// Pin-level control and fault logic of the power manager.
//
// Function
// - Mains loss low starts an immediate full system shutdown.
// - Bus address is read from the three address-select inputs.
// - Crowbar trigger asserts on intermediate bus overvoltage.
// - Four separate auxiliary enable outputs switch auxiliary devices.
// - Front supply enable switches the intermediate bus converter.
// - Cold reset input low performs a cold start of the manager.
// - Four active-low interrupts, each set to group hold or hot-swap.
// - Group-hold interrupt pulls its group fault line, pausing group.
// - Hot-swap interrupt assertion starts programming of its group.
// - Hot-swap interrupt release marks the group's converters detached.
// - Write lock low blocks every write to internal memory.
// - No software control can override the write lock.
// - A group fault line pulled low externally is sensed as fault.
// - Device can pull any group fault line low to disable it.
// - Four auxiliary power-good inputs are sampled as device status.
// - Soft reset low turns off converters and auxiliaries in sequence.
// - Soft reset release reprograms and restarts the whole system.
// - The open-drain sync line distributes the master clock.
// - The sync line carries messages together with the clock.
`include "power_manager_params.svh"

module power_manager_pin_control
  import power_manager_pkg::*;
#(
  parameter int SEQ_STEP_CYC = `SEQ_STEP_CYC,
  parameter int REPROG_CYC   = `REPROG_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic       mains_loss_in_n,
  input  wire logic       cold_reset_in_n,
  input  wire logic       soft_reset_in_n,
  input  wire logic       write_lock_in_n,
  input  wire logic [2:0] addr_sel_in,
  input  wire logic [3:0] irq_in_n,
  input  wire logic [3:0] aux_good_in,
  input  wire logic       overvolt_in,
  input  wire logic       group_fault_line_a_in,
  output logic            group_fault_line_a_out,
  output logic            group_fault_line_a_oe,
  input  wire logic       group_fault_line_b_in,
  output logic            group_fault_line_b_out,
  output logic            group_fault_line_b_oe,
  input  wire logic       group_fault_line_c_in,
  output logic            group_fault_line_c_out,
  output logic            group_fault_line_c_oe,
  input  wire logic       group_fault_line_d_in,
  output logic            group_fault_line_d_out,
  output logic            group_fault_line_d_oe,
  input  wire logic       sync_message_line_in,
  output logic            sync_message_line_out,
  output logic            sync_message_line_oe,
  input  wire logic [3:0] irq_mode_cfg,
  input  wire logic [3:0] aux_enable_cfg,
  input  wire logic       front_enable_cfg,
  input  wire logic [3:0] group_disable_cfg,
  input  wire logic       mem_write_req,
  input  wire logic       msg_valid,
  input  wire logic [7:0] msg_data,
  output logic            msg_ready,
  output logic [7:0]      msg_rx_data,
  output logic            msg_rx_valid,
  output logic [2:0]      bus_addr_out,
  output logic            crowbar_trigger_out,
  output logic            front_supply_on_out,
  output logic [3:0]      aux_on_out,
  output logic [3:0]      aux_status_out,
  output logic [3:0]      group_fault_seen_out,
  output logic [3:0]      hot_program_out,
  output logic [3:0]      hot_detach_out,
  output logic            shutdown_out,
  output logic            cold_start_out,
  output logic            reprogram_out,
  output logic            mem_write_en_out
);

  if (SEQ_STEP_CYC < 1 || SEQ_STEP_CYC > 65535 ||
      REPROG_CYC < 1 || REPROG_CYC > 65535) begin : g_bad_counts
    $error("sequencer counts out of range");
  end

  logic [`SYNC_VEC_W-1:0] async_vec;
  logic [`SYNC_VEC_W-1:0] sync1_reg;
  logic [`SYNC_VEC_W-1:0] sync2_reg;
  logic                   mains_s;
  logic                   cold_s;
  logic                   soft_s;
  logic                   lock_s;
  logic [2:0]             addr_s;
  logic [3:0]             irq_s;
  logic [3:0]             good_s;
  logic [3:0]             fault_s;
  logic                   line_s;
  logic                   ov_s;
  logic [3:0]             irq_prev_reg;
  logic [3:0]             fault_oe_reg;
  logic [3:0]             hold_req;
  logic [3:0]             aux_next;
  logic [3:0]             oe_next;
  logic                   front_next;
  logic                   zero_reg;
  state_t                 state_reg;
  state_t                 state_next;
  logic [15:0]            step_cnt_reg;
  logic [2:0]             seq_step_reg;
  logic                   step_done;
  logic                   reprog_done;

  assign async_vec = {overvolt_in, sync_message_line_in,
                      group_fault_line_d_in, group_fault_line_c_in,
                      group_fault_line_b_in, group_fault_line_a_in,
                      aux_good_in, irq_in_n, addr_sel_in,
                      write_lock_in_n, soft_reset_in_n, cold_reset_in_n,
                      mains_loss_in_n};

  // Pins are asynchronous to core_clk; only the second stage is read.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      sync1_reg <= `SYNC_VEC_RST;
      sync2_reg <= `SYNC_VEC_RST;
    end else begin
      sync1_reg <= async_vec;
      sync2_reg <= sync1_reg;
    end
  end

  assign mains_s = sync2_reg[0];
  assign cold_s  = sync2_reg[1];
  assign soft_s  = sync2_reg[2];
  assign lock_s  = sync2_reg[3];
  assign addr_s  = sync2_reg[6:4];
  assign irq_s   = sync2_reg[10:7];
  assign good_s  = sync2_reg[14:11];
  assign fault_s = sync2_reg[18:15];
  assign line_s  = sync2_reg[19];
  assign ov_s    = sync2_reg[20];

  assign step_done   = (step_cnt_reg == 16'(SEQ_STEP_CYC - 1));
  assign reprog_done = (step_cnt_reg == 16'(REPROG_CYC - 1));

  always_comb begin
    state_next = state_reg;
    if (!cold_s) begin
      state_next = ST_COLD;
    end else if (!mains_s) begin
      state_next = ST_SHUT;
    end else begin
      case (state_reg)
        ST_COLD:    state_next = ST_REPROG;
        ST_SHUT:    state_next = ST_REPROG;
        ST_RUN: begin
          if (!soft_s) begin
            state_next = ST_SEQ_OFF;
          end
        end
        ST_SEQ_OFF: begin
          if (step_done && seq_step_reg == `SEQ_LAST_STEP) begin
            state_next = ST_HELD;
          end
        end
        ST_HELD: begin
          if (soft_s) begin
            state_next = ST_REPROG;
          end
        end
        ST_REPROG: begin
          if (!soft_s) begin
            state_next = ST_SEQ_OFF;
          end else if (reprog_done) begin
            state_next = ST_RUN;
          end
        end
        default:    state_next = ST_COLD;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      state_reg <= ST_COLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // One timer paces both the shutdown steps and the reprogram window.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      step_cnt_reg <= 16'h0000;
      seq_step_reg <= 3'd0;
    end else if (state_next != state_reg) begin
      step_cnt_reg <= 16'h0000;
      seq_step_reg <= 3'd0;
    end else if (state_reg == ST_SEQ_OFF && step_done) begin
      step_cnt_reg <= 16'h0000;
      seq_step_reg <= seq_step_reg + 3'd1;
    end else begin
      step_cnt_reg <= step_cnt_reg + 16'h0001;
    end
  end

  // Group-hold interrupts pull their own group line while asserted.
  assign hold_req = ~irq_s & ~irq_mode_cfg;

  // Soft-reset shutdown drops group lines first, then one auxiliary per step.
  always_comb begin
    aux_next   = 4'h0;
    oe_next    = 4'hf;
    front_next = 1'b0;
    case (state_next)
      ST_RUN: begin
        oe_next    = group_disable_cfg | hold_req;
        aux_next   = aux_enable_cfg & ~hold_req & fault_s;
        front_next = front_enable_cfg;
      end
      ST_REPROG: begin
        front_next = front_enable_cfg;
      end
      ST_SEQ_OFF: begin
        for (int i = 0; i < 4; i++) begin
          aux_next[i] = aux_on_out[i] && (seq_step_reg <= 3'(i));
        end
        front_next = front_enable_cfg;
      end
      ST_HELD: begin
        front_next = front_enable_cfg;
      end
      ST_SHUT: begin
        front_next = 1'b0;
      end
      ST_COLD: begin
        front_next = 1'b0;
      end
      default: begin
        front_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      aux_on_out          <= 4'h0;
      fault_oe_reg        <= 4'hf;
      front_supply_on_out <= 1'b0;
    end else begin
      aux_on_out          <= aux_next;
      fault_oe_reg        <= oe_next;
      front_supply_on_out <= front_next && !crowbar_trigger_out;
    end
  end

  assign group_fault_line_a_oe = fault_oe_reg[0];
  assign group_fault_line_b_oe = fault_oe_reg[1];
  assign group_fault_line_c_oe = fault_oe_reg[2];
  assign group_fault_line_d_oe = fault_oe_reg[3];

  // Open-drain pins only ever drive low.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      zero_reg <= 1'b0;
    end else begin
      zero_reg <= 1'b0;
    end
  end

  assign group_fault_line_a_out = zero_reg;
  assign group_fault_line_b_out = zero_reg;
  assign group_fault_line_c_out = zero_reg;
  assign group_fault_line_d_out = zero_reg;
  assign sync_message_line_out  = zero_reg;

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      shutdown_out   <= 1'b0;
      cold_start_out <= 1'b0;
      reprogram_out  <= 1'b0;
    end else begin
      shutdown_out   <= (state_next == ST_SHUT);
      cold_start_out <= (state_reg == ST_COLD) && (state_next != ST_COLD);
      reprogram_out  <= (state_next == ST_REPROG);
    end
  end

  // The crowbar stays latched until a cold start clears it.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      crowbar_trigger_out <= 1'b0;
    end else if (ov_s) begin
      crowbar_trigger_out <= 1'b1;
    end else if (!cold_s) begin
      crowbar_trigger_out <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      irq_prev_reg    <= 4'hf;
      hot_program_out <= 4'h0;
      hot_detach_out  <= 4'h0;
    end else begin
      irq_prev_reg    <= irq_s;
      hot_program_out <= irq_prev_reg & ~irq_s & irq_mode_cfg;
      hot_detach_out  <= ~irq_prev_reg & irq_s & irq_mode_cfg;
    end
  end

  // Only the lock pin gates writes; no configuration input reaches it.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      mem_write_en_out <= 1'b0;
    end else begin
      mem_write_en_out <= mem_write_req && lock_s;
    end
  end

  // A low line that this device is not pulling is someone else's fault.
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      group_fault_seen_out <= 4'h0;
      aux_status_out       <= 4'h0;
      bus_addr_out         <= 3'd0;
    end else begin
      group_fault_seen_out <= ~fault_s & ~fault_oe_reg;
      aux_status_out       <= good_s;
      bus_addr_out         <= addr_s;
    end
  end

  sync_line_tx u_sync_line (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .tx_valid  (msg_valid),
    .tx_data   (msg_data),
    .tx_ready  (msg_ready),
    .line_sync (line_s),
    .line_oe   (sync_message_line_oe),
    .rx_data   (msg_rx_data),
    .rx_valid  (msg_rx_valid)
  );

  default clocking cb_main @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence soft_enter_s;
    (state_reg == ST_RUN && cold_s && mains_s && !soft_s)
      ##1 (state_reg == ST_SEQ_OFF);
  endsequence

  // Releasing soft reset, or a higher-priority reset, ends the wait early.
  sequence all_off_s;
    ##[1:600] ((aux_on_out == 4'h0 && state_reg == ST_HELD) ||
               soft_s || !cold_s || !mains_s);
  endsequence

  AST_MAINS_SHUT: assert property (
    (cold_s && !mains_s) |=> (shutdown_out && !front_supply_on_out &&
                              aux_on_out == 4'h0))
    else $error("mains loss did not shut down at once");

  AST_ADDR: assert property (
    $stable(addr_s) |=> (bus_addr_out == $past(addr_s)))
    else $error("bus address does not follow select inputs");

  AST_CROWBAR: assert property (
    ov_s |=> crowbar_trigger_out [*2])
    else $error("crowbar not asserted on overvoltage");

  AST_AUX_OFF: assert property (
    (state_reg inside {ST_COLD, ST_HELD, ST_SHUT}) |-> (aux_on_out == 4'h0))
    else $error("auxiliary enabled while system is off");

  AST_COLD: assert property (
    !cold_s |=> (state_reg == ST_COLD && !front_supply_on_out))
    else $error("cold reset did not restart the manager");

  AST_HOLD: assert property (
    (!irq_mode_cfg[0] && !irq_s[0] && cold_s && mains_s &&
     state_reg == ST_RUN && soft_s) |=> group_fault_line_a_oe)
    else $error("group hold did not pull fault line");

  AST_HOT_PROG: assert property (
    (irq_mode_cfg[0] && $fell(irq_s[0])) |=> (hot_program_out[0]
                                              ##1 !hot_program_out[0]))
    else $error("hot-swap assertion did not start programming");

  AST_HOT_DETACH: assert property (
    (irq_mode_cfg[1] && $rose(irq_s[1])) |=> hot_detach_out[1])
    else $error("hot-swap release not reported as detach");

  AST_LOCK: assert property (
    !lock_s |=> !mem_write_en_out)
    else $error("memory write passed while locked");

  AST_FAULT_SENSE: assert property (
    (!fault_s[2] && !fault_oe_reg[2]) |=> group_fault_seen_out[2])
    else $error("external group fault not sensed");

  AST_SOFT_SEQ: assert property (
    soft_enter_s |-> all_off_s)
    else $error("soft reset did not sequence everything off");

  AST_REPROG: assert property (
    (state_reg == ST_HELD && soft_s && cold_s && mains_s) |=>
      (state_reg == ST_REPROG && reprogram_out))
    else $error("soft reset release did not reprogram");

  AST_SYNC_STAGE: assert property (
    $changed(mains_loss_in_n) |-> ##2 (mains_s == $past(mains_loss_in_n, 2)))
    else $error("mains loss input not delayed two stages");

endmodule : power_manager_pin_control

// [dv/far_side_model.sv]
// Far-side model: auxiliary devices, fault network and pulled-up lines.
module far_side_model (
  input  wire logic       core_clk,
  input  wire logic [3:0] aux_on,
  input  wire logic [3:0] group_oe,
  input  wire logic [3:0] fault_pull,
  input  wire logic       sync_oe,
  output logic [3:0]      aux_good,
  output logic [3:0]      group_line,
  output logic            sync_line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] good_d1_reg = 4'h0;
  logic [3:0] good_d2_reg = 4'h0;
  // Power-good follows the enable two cycles late, like a slow regulator.
  always @(posedge core_clk) begin
    good_d1_reg <= aux_on;
    good_d2_reg <= good_d1_reg;
  end
  assign aux_good = good_d2_reg;
  // Pull-ups make released lines read high; any party may pull one low.
  assign group_line = ~(group_oe | fault_pull);
  assign sync_line  = ~sync_oe;
  // No test-port programmer is modelled; this block has no test port.
endmodule : far_side_model

// [dv/tb.sv]
// Self-checking bench of the power manager pin control.
`include "power_manager_params.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
`define WAITC(c, n) for (int wi = 0; wi < (n) && !(c); wi++) \
  @(negedge core_clk);

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       core_clk = 1'b0;
  logic       nrst, mains_loss_in_n, cold_reset_in_n, soft_reset_in_n;
  logic       write_lock_in_n, overvolt_in, front_enable_cfg;
  logic       mem_write_req, msg_valid, msg_ready, msg_rx_valid;
  logic       sync_message_line_in, sync_message_line_oe;
  logic       crowbar_trigger_out, front_supply_on_out, shutdown_out;
  logic       cold_start_out, reprogram_out, mem_write_en_out;
  logic       group_fault_line_a_oe, group_fault_line_b_oe;
  logic       group_fault_line_c_oe, group_fault_line_d_oe;
  logic [2:0] addr_sel_in, bus_addr_out;
  logic [3:0] irq_in_n, aux_good_in, irq_mode_cfg, aux_enable_cfg;
  logic [3:0] group_disable_cfg, aux_on_out, aux_status_out, fault_pull;
  logic [3:0] group_fault_seen_out, hot_program_out, hot_detach_out;
  logic [3:0] gline, goe, hold, exp_aux;
  logic [4:0] lo;
  logic [7:0] msg_data, msg_rx_data, rnd;
  int         mismatches, samples_checked, cycles, n_hi;

  assign goe = {group_fault_line_d_oe, group_fault_line_c_oe,
                group_fault_line_b_oe, group_fault_line_a_oe};

  power_manager_pin_control #(.SEQ_STEP_CYC(4), .REPROG_CYC(8)) dut_u (
    .core_clk, .nrst, .mains_loss_in_n, .cold_reset_in_n,
    .soft_reset_in_n, .write_lock_in_n, .addr_sel_in, .irq_in_n,
    .aux_good_in, .overvolt_in, .group_fault_line_a_in(gline[0]),
    .group_fault_line_a_out(lo[0]), .group_fault_line_a_oe,
    .group_fault_line_b_in(gline[1]), .group_fault_line_b_out(lo[1]),
    .group_fault_line_b_oe, .group_fault_line_c_in(gline[2]),
    .group_fault_line_c_out(lo[2]), .group_fault_line_c_oe,
    .group_fault_line_d_in(gline[3]), .group_fault_line_d_out(lo[3]),
    .group_fault_line_d_oe, .sync_message_line_in,
    .sync_message_line_out(lo[4]), .sync_message_line_oe, .irq_mode_cfg,
    .aux_enable_cfg, .front_enable_cfg, .group_disable_cfg,
    .mem_write_req, .msg_valid, .msg_data, .msg_ready, .msg_rx_data,
    .msg_rx_valid, .bus_addr_out, .crowbar_trigger_out,
    .front_supply_on_out, .aux_on_out, .aux_status_out,
    .group_fault_seen_out, .hot_program_out, .hot_detach_out,
    .shutdown_out, .cold_start_out, .reprogram_out, .mem_write_en_out);

  far_side_model far_u (.core_clk, .aux_on(aux_on_out), .group_oe(goe),
    .fault_pull, .sync_oe(sync_message_line_oe), .aux_good(aux_good_in),
    .group_line(gline), .sync_line(sync_message_line_in));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask : cyc

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    {nrst, overvolt_in, mem_write_req, msg_valid, front_enable_cfg} = '0;
    {mains_loss_in_n, cold_reset_in_n, soft_reset_in_n} = 3'h7;
    write_lock_in_n = 1'b1;
    {addr_sel_in, irq_mode_cfg, aux_enable_cfg} = '0;
    {group_disable_cfg, fault_pull, msg_data} = '0;
    irq_in_n = 4'hf;
    rnd = 8'h3f;
    cyc(20);
    `CHK("reset_lines", 4'hf, goe)
    nrst = 1'b1;
    `WAITC(cold_start_out, 5)
    `CHK("cold_start", 1'b1, cold_start_out)
    `CHK("drive_low", 5'h00, lo)
    `WAITC(!reprogram_out, 20)
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      {aux_enable_cfg, irq_in_n} = rnd;
      rnd = lfsr(rnd);
      {irq_mode_cfg, group_disable_cfg} = rnd;
      rnd = lfsr(rnd);
      {fault_pull, addr_sel_in, front_enable_cfg} = rnd;
      rnd = lfsr(rnd);
      {write_lock_in_n, mem_write_req} = rnd[1:0];
      hold = ~irq_in_n & ~irq_mode_cfg;
      exp_aux = aux_enable_cfg & ~(hold | group_disable_cfg | fault_pull);
      cyc(12);
      `CHK("addr", addr_sel_in, bus_addr_out)
      `CHK("front", front_enable_cfg, front_supply_on_out)
      `CHK("aux_on", exp_aux, aux_on_out)
      `CHK("lines", hold | group_disable_cfg, goe)
      `CHK("seen", fault_pull & ~goe, group_fault_seen_out)
      `CHK("aux_stat", exp_aux, aux_status_out)
      `CHK("wr_en", mem_write_req & write_lock_in_n,
           mem_write_en_out)
    end
    {irq_in_n, aux_enable_cfg, irq_mode_cfg} = 12'hfff;
    {group_disable_cfg, fault_pull, front_enable_cfg} = '0;
    cyc(4);
    for (int g = 0; g < 4; g++) begin
      irq_in_n[g] = 1'b0;
      `WAITC(hot_program_out[g], 8)
      `CHK("hot_prog", 4'h1 << g, hot_program_out)
      `CHK("hot_nohold", 4'h0, goe)
      irq_in_n[g] = 1'b1;
      `WAITC(hot_detach_out[g], 8)
      `CHK("hot_det", 4'h1 << g, hot_detach_out)
    end
    irq_mode_cfg = 4'h0;
    front_enable_cfg = 1'b1;
    cyc(10);
    `CHK("aux_run", 4'hf, aux_on_out)
    soft_reset_in_n = 1'b0;
    `WAITC(!aux_on_out[0], 40)
    `CHK("seq_first", 4'he, aux_on_out)
    `WAITC(aux_on_out == 4'h0, 40)
    `CHK("seq_done", 4'h0, aux_on_out)
    `CHK("seq_lines", 4'hf, goe)
    soft_reset_in_n = 1'b1;
    `WAITC(reprogram_out, 8)
    `CHK("soft_reprog", 1'b1, reprogram_out)
    `WAITC(!reprogram_out, 20)
    cyc(8);
    `CHK("soft_restart", 4'hf, aux_on_out)
    mains_loss_in_n = 1'b0;
    cyc(3);
    `CHK("shutdown", 1'b1, shutdown_out)
    `CHK("shut_front", 1'b0, front_supply_on_out)
    `CHK("shut_aux", 4'h0, aux_on_out)
    mains_loss_in_n = 1'b1;
    `WAITC(reprogram_out, 8)
    `WAITC(!reprogram_out, 20)
    overvolt_in = 1'b1;
    cyc(3);
    `CHK("crowbar", 1'b1, crowbar_trigger_out)
    overvolt_in = 1'b0;
    cyc(6);
    `CHK("crowbar_hold", 1'b1, crowbar_trigger_out)
    `CHK("crowbar_front", 1'b0, front_supply_on_out)
    cold_reset_in_n = 1'b0;
    cyc(3);
    `CHK("cold_clear", 1'b0, crowbar_trigger_out)
    `CHK("cold_lines", 4'hf, goe)
    cold_reset_in_n = 1'b1;
    `WAITC(cold_start_out, 8)
    `CHK("cold_again", 1'b1, cold_start_out)
    `WAITC(!reprogram_out, 20)
    cyc(8);
    `CHK("front_back", 1'b1, front_supply_on_out)
    n_hi = 0;
    for (int i = 0; i < 2 * `SYNC_BIT_CYC; i++) begin
      @(negedge core_clk);
      n_hi += int'(sync_message_line_oe);
    end
    `CHK("sync_clock", 2 * `SYNC_ONE_CYC, n_hi)
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      msg_data = rnd;
      msg_valid = 1'b1;
      `WAITC(msg_ready, 250)
      `WAITC(!msg_ready, 250)
      msg_valid = 1'b0;
      `WAITC(msg_rx_valid, 2000)
      `CHK("sync_msg", rnd, msg_rx_data)
    end
    results();
  end
endmodule : tb
